// ---- pkg/fault_map.svh ----
// Register offsets, field positions, reset values and code constants of the fault unit
`ifndef FAULT_UNIT_MAP_SVH
`define FAULT_UNIT_MAP_SVH

// Byte offsets, decoded from haddr[7:0]
`define OFF_HARD_CAUSE 8'h00
`define OFF_PROTECT_CAUSE 8'h04
`define OFF_BUS_CAUSE 8'h08
`define OFF_USAGE_CAUSE 8'h0C
`define OFF_PROTECT_ADDR 8'h10
`define OFF_BUS_ADDR 8'h14
`define OFF_PRIO_CONFIG 8'h18
`define OFF_HANDLER_ENABLE 8'h1C
`define OFF_UNIT_STATUS 8'h20

// Cause field widths
`define HARD_W 2
`define PROT_W 4
`define BUS_W 5
`define USAGE_W 6

// Hard fault cause bits
`define HB_TABLE_READ 0
`define HB_ESCALATION 1
// Protection fault cause bits
`define PB_FETCH 0
`define PB_DATA 1
`define PB_PUSH 2
`define PB_POP 3
// Bus fault cause bits
`define BB_PUSH 0
`define BB_POP 1
`define BB_PREFETCH 2
`define BB_PRECISE 3
`define BB_DEFERRED 4
// Usage fault cause bits
`define UB_COPROC 0
`define UB_UNKNOWN_OP 1
`define UB_BAD_STATE 2
`define UB_BAD_RETURN 3
`define UB_MISALIGNED 4
`define UB_ZERO_DIV 5

// Priority field layout
`define PRIO_W 8
`define PRIO_PROT_LSB 0
`define PRIO_BUS_LSB 8
`define PRIO_USAGE_LSB 16
`define PRIO_RESET 24'h000000

// Handler enable bits
`define EN_PROT 0
`define EN_BUS 1
`define EN_USAGE 2
`define EN_RESET 3'h0

// Status bits
`define ST_LOCKUP 0
`define ST_PROT_ADDR_VALID 1
`define ST_BUS_ADDR_VALID 2
`define ST_LOCK_FROM_NMI 3

// Valid exception return codes
`define RET_HANDLER_MAIN 32'hFFFFFFF1
`define RET_THREAD_MAIN 32'hFFFFFFF9
`define RET_THREAD_PROCESS 32'hFFFFFFFD

`define WORD_ZERO 32'h00000000

`endif

// ---- pkg/fault_pkg.sv ----
// Types shared by the fault escalation unit
package fault_pkg;

	// Context the core is executing in
	typedef enum logic [2:0] {
		CTX_THREAD = 3'h0,
		CTX_NMI = 3'h1,
		CTX_HARD = 3'h2,
		CTX_PROTECT = 3'h3,
		CTX_BUS = 3'h4,
		CTX_USAGE = 3'h5,
		CTX_OTHER = 3'h6
	} ctx_t;

	// Handler that a taken fault is routed to
	typedef enum logic [1:0] {
		CLASS_HARD = 2'h0,
		CLASS_PROTECT = 2'h1,
		CLASS_BUS = 2'h2,
		CLASS_USAGE = 2'h3
	} class_t;

	typedef enum logic [2:0] {
		LK_RUN = 3'h1,
		LK_FROM_HARD = 3'h2,
		LK_FROM_NMI = 3'h4
	} lock_state_t;

endpackage

// ---- logic/sticky_cause.sv ----
// Sticky cause flags with write-one-to-clear, set beating clear
`timescale 1ns/1ps
module sticky_cause #(
	parameter int W = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [W-1:0] set_in,
	input wire logic [W-1:0] clr_in,
	output logic [W-1:0] flags_out
);

	logic [W-1:0] flags_ff;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			flags_ff <= '0;
		end else if (ce_in) begin
			flags_ff <= (flags_ff & ~clr_in) | set_in;
		end
	end

	assign flags_out = flags_ff;

	generate
		for (genvar i = 0; i < W; i++) begin : g_chk
			set_wins_a: assert property (@(posedge clk_in) disable iff (rst_in)
				ce_in && set_in[i] |=> flags_ff[i])
				else $error("cause flag lost on set");
			flag_holds_a: assert property (@(posedge clk_in) disable iff (rst_in)
				flags_ff[i] && !(ce_in && clr_in[i]) |=> flags_ff[i])
				else $error("cause flag dropped without clear");
		end
	endgenerate

endmodule

// ---- logic/fault_escalate.sv ----
// Escalation decision for one configurable-priority fault class
`timescale 1ns/1ps
module fault_escalate #(
	parameter int PW = 8
) (
	input wire logic event_in,
	input wire logic exempt_in,
	input wire logic enable_in,
	input wire logic same_kind_in,
	input wire logic fixed_ctx_in,
	input wire logic ctx_valid_in,
	input wire logic [PW-1:0] prio_in,
	input wire logic [PW-1:0] ctx_prio_in,
	output logic escalate_out,
	output logic direct_out
);

	logic cannot_preempt;

	// Numerically larger means lower urgency
	assign cannot_preempt = same_kind_in
		|| fixed_ctx_in
		|| (ctx_valid_in && (prio_in >= ctx_prio_in));

	assign escalate_out = event_in && !exempt_in
		&& (!enable_in || cannot_preempt);
	assign direct_out = event_in && !escalate_out;

endmodule

// ---- logic/fault_unit.sv ----
// Fault classification, escalation and lockup unit with AHB-Lite registers
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fault_map.svh"

// Functional notes
// - Vector table read bus error becomes hard fault, sets table read flag.
// - Escalated configurable fault sets the escalation flag in hard cause.
// - Protection violations raise protect fault with fetch, data, push, pop flags.
// - Fetch from execute-never region raises fetch protect fault even without MPU.
// - Push, pop and prefetch bus errors raise bus fault, each own flag.
// - Data bus errors flag precise and deferred separately.
// - Six usage fault causes each set their own flag.
// - Bad exec state: foreign instruction set or continuation-state return.
// - Configurable classes have software priority; hard fault priority fixed.
// - Disabled handler makes its fault escalate to hard fault.
// - Handler faulting its own kind escalates to hard fault.
// - Fault at same or lower priority than current context escalates.
// - Bus error pushing for bus handler entry does not escalate.
// - Hard fault preempts all but reset, NMI and hard fault.
// - Protect and non-deferred bus faults record faulting address; deferred bus, hard, usage do not.
// - Hard fault inside NMI or hard handler enters lockup.
// - Lockup persists until reset, NMI or debugger halt.
// - Lockup entered from NMI handler ignores later NMI.
// - Only three exception return codes valid; rest invalid return.
module fault_unit
	import fault_pkg::*;
#(
	parameter int PRIO_W = `PRIO_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Core context
	input wire logic [2:0] active_ctx_in,
	input wire logic [PRIO_W-1:0] active_prio_in,
	input wire logic nmi_in,
	input wire logic debug_halt_in,
	// Event reports
	input wire logic table_read_err_in,
	input wire logic fetch_protect_in,
	input wire logic fetch_execute_never_in,
	input wire logic data_protect_in,
	input wire logic push_protect_in,
	input wire logic pop_protect_in,
	input wire logic [31:0] protect_addr_in,
	input wire logic push_bus_err_in,
	input wire logic bus_entry_push_in,
	input wire logic pop_bus_err_in,
	input wire logic prefetch_bus_err_in,
	input wire logic precise_bus_err_in,
	input wire logic deferred_bus_err_in,
	input wire logic [31:0] bus_addr_in,
	input wire logic coproc_access_in,
	input wire logic unknown_opcode_in,
	input wire logic foreign_iset_in,
	input wire logic continuation_return_in,
	input wire logic return_strobe_in,
	input wire logic [31:0] return_code_in,
	input wire logic misaligned_in,
	input wire logic zero_divisor_in,
	// Decisions
	output logic fault_take_out,
	output logic [1:0] fault_class_out,
	output logic lockup_out
);

	ctx_t ctx;
	logic fixed_ctx, ctx_valid;
	logic [`HARD_W-1:0] hard_set, hard_clr, hard_cause;
	logic [`PROT_W-1:0] prot_set, prot_clr, prot_cause;
	logic [`BUS_W-1:0] bus_set, bus_clr, bus_cause;
	logic [`USAGE_W-1:0] usage_set, usage_clr, usage_cause;
	logic prot_evt, bus_evt, usage_evt, bad_return;
	logic esc_prot, esc_bus, esc_usage, dir_prot, dir_bus, dir_usage;
	logic esc_any, hard_evt;
	logic [23:0] prio_ff;
	logic [2:0] enable_ff;
	logic [31:0] prot_addr_ff, bus_addr_ff;
	logic prot_addr_valid_ff, bus_addr_valid_ff;
	lock_state_t lock_ff, nxt_lock;
	logic take_ff, nxt_take, lockup_ff;
	class_t class_ff, nxt_class;
	logic addr_phase, wr_pend_ff, rd_pend_ff;
	logic [7:0] bus_off_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff, hresp_ff;
	logic wr_now;
	logic [31:0] rd_value;

	assign ctx = ctx_t'(active_ctx_in);
	assign fixed_ctx = (ctx == CTX_NMI) || (ctx == CTX_HARD);
	assign ctx_valid = (ctx != CTX_THREAD);

	// Event classification
	assign bad_return = return_strobe_in
		&& (return_code_in != `RET_HANDLER_MAIN)
		&& (return_code_in != `RET_THREAD_MAIN)
		&& (return_code_in != `RET_THREAD_PROCESS);

	always_comb begin
		hard_set = '0;
		prot_set = '0;
		bus_set = '0;
		usage_set = '0;
		hard_set[`HB_TABLE_READ] = table_read_err_in;
		prot_set[`PB_FETCH] = fetch_protect_in || fetch_execute_never_in;
		prot_set[`PB_DATA] = data_protect_in;
		prot_set[`PB_PUSH] = push_protect_in;
		prot_set[`PB_POP] = pop_protect_in;
		bus_set[`BB_PUSH] = push_bus_err_in;
		bus_set[`BB_POP] = pop_bus_err_in;
		bus_set[`BB_PREFETCH] = prefetch_bus_err_in;
		bus_set[`BB_PRECISE] = precise_bus_err_in;
		bus_set[`BB_DEFERRED] = deferred_bus_err_in;
		usage_set[`UB_COPROC] = coproc_access_in;
		usage_set[`UB_UNKNOWN_OP] = unknown_opcode_in;
		usage_set[`UB_BAD_STATE] = foreign_iset_in || continuation_return_in;
		usage_set[`UB_BAD_RETURN] = bad_return;
		usage_set[`UB_MISALIGNED] = misaligned_in;
		usage_set[`UB_ZERO_DIV] = zero_divisor_in;
		hard_set[`HB_ESCALATION] = esc_any;
	end

	assign prot_evt = |prot_set;
	assign bus_evt = |bus_set;
	assign usage_evt = |usage_set;

	// Escalation per configurable class
	fault_escalate #(.PW(PRIO_W)) u_esc_prot (
		.event_in(prot_evt), .exempt_in(1'b0), .enable_in(enable_ff[`EN_PROT]),
		.same_kind_in(ctx == CTX_PROTECT), .fixed_ctx_in(fixed_ctx), .ctx_valid_in(ctx_valid),
		.prio_in(prio_ff[`PRIO_PROT_LSB +: PRIO_W]), .ctx_prio_in(active_prio_in),
		.escalate_out(esc_prot), .direct_out(dir_prot));
	fault_escalate #(.PW(PRIO_W)) u_esc_bus (
		.event_in(bus_evt), .exempt_in(push_bus_err_in && bus_entry_push_in),
		.enable_in(enable_ff[`EN_BUS]), .same_kind_in(ctx == CTX_BUS),
		.fixed_ctx_in(fixed_ctx), .ctx_valid_in(ctx_valid),
		.prio_in(prio_ff[`PRIO_BUS_LSB +: PRIO_W]), .ctx_prio_in(active_prio_in),
		.escalate_out(esc_bus), .direct_out(dir_bus));
	fault_escalate #(.PW(PRIO_W)) u_esc_usage (
		.event_in(usage_evt), .exempt_in(1'b0), .enable_in(enable_ff[`EN_USAGE]),
		.same_kind_in(ctx == CTX_USAGE), .fixed_ctx_in(fixed_ctx), .ctx_valid_in(ctx_valid),
		.prio_in(prio_ff[`PRIO_USAGE_LSB +: PRIO_W]), .ctx_prio_in(active_prio_in),
		.escalate_out(esc_usage), .direct_out(dir_usage));

	assign esc_any = esc_prot || esc_bus || esc_usage;
	assign hard_evt = table_read_err_in || esc_any;

	// Cause registers
	sticky_cause #(.W(`HARD_W)) u_hard_cause (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.set_in(hard_set), .clr_in(hard_clr), .flags_out(hard_cause));
	sticky_cause #(.W(`PROT_W)) u_prot_cause (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.set_in(prot_set), .clr_in(prot_clr), .flags_out(prot_cause));
	sticky_cause #(.W(`BUS_W)) u_bus_cause (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.set_in(bus_set), .clr_in(bus_clr), .flags_out(bus_cause));
	sticky_cause #(.W(`USAGE_W)) u_usage_cause (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.set_in(usage_set), .clr_in(usage_clr), .flags_out(usage_cause));

	// Faulting address capture; deferred errors carry no usable address
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prot_addr_ff <= `WORD_ZERO;
			bus_addr_ff <= `WORD_ZERO;
			prot_addr_valid_ff <= 1'b0;
			bus_addr_valid_ff <= 1'b0;
		end else if (ce_in) begin
			if (prot_evt) begin
				prot_addr_ff <= protect_addr_in;
				prot_addr_valid_ff <= 1'b1;
			end
			if (bus_evt && !deferred_bus_err_in) begin
				bus_addr_ff <= bus_addr_in;
				bus_addr_valid_ff <= 1'b1;
			end
		end
	end

	// Handler selection and lockup
	always_comb begin
		nxt_lock = lock_ff;
		nxt_take = 1'b0;
		nxt_class = class_ff;
		case (lock_ff)
			LK_RUN: begin
				if (hard_evt && ctx == CTX_NMI) begin
					nxt_lock = LK_FROM_NMI;
				end else if (hard_evt && ctx == CTX_HARD) begin
					nxt_lock = LK_FROM_HARD;
				end else if (hard_evt) begin
					nxt_take = 1'b1;
					nxt_class = CLASS_HARD;
				end else if (dir_prot) begin
					nxt_take = 1'b1;
					nxt_class = CLASS_PROTECT;
				end else if (dir_bus) begin
					nxt_take = 1'b1;
					nxt_class = CLASS_BUS;
				end else if (dir_usage) begin
					nxt_take = 1'b1;
					nxt_class = CLASS_USAGE;
				end
			end
			LK_FROM_HARD: begin
				if (nmi_in || debug_halt_in) begin
					nxt_lock = LK_RUN;
				end
			end
			LK_FROM_NMI: begin
				if (debug_halt_in) begin
					nxt_lock = LK_RUN;
				end
			end
			default: begin
				nxt_lock = LK_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lock_ff <= LK_RUN;
			lockup_ff <= 1'b0;
			take_ff <= 1'b0;
			class_ff <= CLASS_HARD;
		end else if (ce_in) begin
			lock_ff <= nxt_lock;
			lockup_ff <= (nxt_lock != LK_RUN);
			take_ff <= nxt_take;
			class_ff <= nxt_class;
		end
	end

	assign fault_take_out = take_ff;
	assign fault_class_out = class_ff;
	assign lockup_out = lockup_ff;

	// Bus slave: writes land in the data phase, reads insert one wait state
	assign addr_phase = hsel_in && htrans_in[1] && hready_in;
	assign wr_now = wr_pend_ff && ce_in;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			bus_off_ff <= 8'h00;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end else if (ce_in) begin
			wr_pend_ff <= addr_phase && hwrite_in;
			rd_pend_ff <= addr_phase && !hwrite_in;
			hreadyout_ff <= !(addr_phase && !hwrite_in);
			if (addr_phase) begin
				bus_off_ff <= haddr_in[7:0];
			end
		end
	end

	assign hard_clr = wr_now && bus_off_ff == `OFF_HARD_CAUSE ? hwdata_in[`HARD_W-1:0] : '0;
	assign prot_clr = wr_now && bus_off_ff == `OFF_PROTECT_CAUSE ? hwdata_in[`PROT_W-1:0] : '0;
	assign bus_clr = wr_now && bus_off_ff == `OFF_BUS_CAUSE ? hwdata_in[`BUS_W-1:0] : '0;
	assign usage_clr = wr_now && bus_off_ff == `OFF_USAGE_CAUSE ? hwdata_in[`USAGE_W-1:0] : '0;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prio_ff <= `PRIO_RESET;
			enable_ff <= `EN_RESET;
		end else if (wr_now) begin
			if (bus_off_ff == `OFF_PRIO_CONFIG) begin
				prio_ff <= hwdata_in[23:0];
			end
			if (bus_off_ff == `OFF_HANDLER_ENABLE) begin
				enable_ff <= hwdata_in[2:0];
			end
		end
	end

	always_comb begin
		rd_value = `WORD_ZERO;
		case (bus_off_ff)
			`OFF_HARD_CAUSE: rd_value[`HARD_W-1:0] = hard_cause;
			`OFF_PROTECT_CAUSE: rd_value[`PROT_W-1:0] = prot_cause;
			`OFF_BUS_CAUSE: rd_value[`BUS_W-1:0] = bus_cause;
			`OFF_USAGE_CAUSE: rd_value[`USAGE_W-1:0] = usage_cause;
			`OFF_PROTECT_ADDR: rd_value = prot_addr_ff;
			`OFF_BUS_ADDR: rd_value = bus_addr_ff;
			`OFF_PRIO_CONFIG: rd_value[23:0] = prio_ff;
			`OFF_HANDLER_ENABLE: rd_value[2:0] = enable_ff;
			`OFF_UNIT_STATUS: begin
				rd_value[`ST_LOCKUP] = (lock_ff != LK_RUN);
				rd_value[`ST_PROT_ADDR_VALID] = prot_addr_valid_ff;
				rd_value[`ST_BUS_ADDR_VALID] = bus_addr_valid_ff;
				rd_value[`ST_LOCK_FROM_NMI] = (lock_ff == LK_FROM_NMI);
			end
			default: rd_value = `WORD_ZERO;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hrdata_ff <= `WORD_ZERO;
		end else if (ce_in && rd_pend_ff) begin
			hrdata_ff <= rd_value;
		end
	end

	assign hrdata_out = hrdata_ff;
	assign hreadyout_out = hreadyout_ff;
	assign hresp_out = hresp_ff;

	// Checks
	table_read_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && table_read_err_in |=> hard_cause[`HB_TABLE_READ])
		else $error("table read error not flagged");
	escalation_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && esc_any |=> hard_cause[`HB_ESCALATION])
		else $error("escalation not flagged");
	never_exec_fetch_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && fetch_execute_never_in |=> prot_cause[`PB_FETCH])
		else $error("execute-never fetch not flagged");
	disabled_escalate_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && usage_evt && !enable_ff[`EN_USAGE] |=> hard_cause[`HB_ESCALATION])
		else $error("disabled usage handler did not escalate");
	prio_escalate_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && prot_evt && ctx_valid
		&& prio_ff[`PRIO_PROT_LSB +: PRIO_W] >= active_prio_in
		|=> hard_cause[`HB_ESCALATION])
		else $error("non-preempting protect fault did not escalate");
	entry_push_direct_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && lock_ff == LK_RUN && push_bus_err_in && bus_entry_push_in
		&& !table_read_err_in && !esc_prot && !esc_usage && !prot_evt
		|=> fault_take_out && fault_class_out == CLASS_BUS)
		else $error("bus entry push error was not taken as bus fault");
	hard_preempt_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && lock_ff == LK_RUN && hard_evt && !fixed_ctx
		|=> fault_take_out && fault_class_out == CLASS_HARD && !lockup_out)
		else $error("hard fault did not preempt");
	lockup_entry_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && lock_ff == LK_RUN && hard_evt && fixed_ctx
		|=> lockup_out && !fault_take_out)
		else $error("lockup not entered");
	lockup_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		lockup_out && !(ce_in && (nmi_in || debug_halt_in)) |=> lockup_out)
		else $error("lockup left without cause");
	nmi_no_release_a: assert property (@(posedge clk_in) disable iff (rst_in)
		lock_ff == LK_FROM_NMI && !debug_halt_in |=> lockup_out)
		else $error("NMI released lockup taken from NMI handler");
	return_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && return_strobe_in && return_code_in == `RET_THREAD_PROCESS
		&& !usage_cause[`UB_BAD_RETURN]
		|=> !usage_cause[`UB_BAD_RETURN])
		else $error("valid return code flagged invalid");

endmodule

// ---- verification/core_event_source.sv ----
// Event source standing in for the pipeline, bus interface and protection unit
`timescale 1ns/1ps
module core_event_source (
	input wire logic fire_in,
	input wire logic [4:0] sel_in,
	output logic [16:0] ev_out
);
	// One-cycle pulse on the selected event line, all others quiet
	always_comb begin
		ev_out = '0;
		if (fire_in) begin
			ev_out[sel_in] = 1'b1;
		end
	end
endmodule

// ---- verification/processor_fault_escalation_unit_test.sv ----
// Self-checking testbench of the fault escalation unit
`timescale 1ns/1ps
`include "fault_map.svh"
module processor_fault_escalation_unit_test;
	import fault_pkg::*;
	logic clk_in = 1'b0, rst_in = 1'b1, hwrite = 1'b0, nmi = 1'b0, dbg = 1'b0, ce = 1'b1;
	logic fire = 1'b0, entry = 1'b0, rstb = 1'b0, hready, hresp, take, lock;
	logic [1:0] htrans = 2'h0, cls;
	logic [2:0] ctx = 3'h0;
	logic [4:0] sel = 5'h00;
	logic [7:0] aprio = 8'h00;
	logic [16:0] ev;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, paddr = 32'h0, baddr = 32'h0, rcode = 32'h0;
	logic [31:0] hrdata;
	logic [7:0] offs [17] = '{8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08,
		8'h08, 8'h08, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C};
	int bits [17] = '{0, 0, 0, 1, 2, 3, 0, 1, 2, 3, 4, 0, 1, 2, 2, 4, 5};
	int num_errors = 0, num_checks = 0;

	core_event_source partner (.fire_in(fire), .sel_in(sel), .ev_out(ev));
	fault_unit #(.PRIO_W(8)) dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
		.hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .active_ctx_in(ctx),
		.active_prio_in(aprio), .nmi_in(nmi), .debug_halt_in(dbg),
		.table_read_err_in(ev[0]), .fetch_protect_in(ev[1]), .fetch_execute_never_in(ev[2]),
		.data_protect_in(ev[3]), .push_protect_in(ev[4]), .pop_protect_in(ev[5]),
		.protect_addr_in(paddr), .push_bus_err_in(ev[6]), .bus_entry_push_in(entry),
		.pop_bus_err_in(ev[7]), .prefetch_bus_err_in(ev[8]), .precise_bus_err_in(ev[9]),
		.deferred_bus_err_in(ev[10]), .bus_addr_in(baddr), .coproc_access_in(ev[11]),
		.unknown_opcode_in(ev[12]), .foreign_iset_in(ev[13]),
		.continuation_return_in(ev[14]), .return_strobe_in(rstb), .return_code_in(rcode),
		.misaligned_in(ev[15]), .zero_divisor_in(ev[16]), .fault_take_out(take),
		.fault_class_out(cls), .lockup_out(lock));

	initial begin
		forever #4 clk_in = ~clk_in;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Address phase held until hready, then data phase held until hready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_in);
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		check(what, q, exp);
	endtask

	task automatic clear_all();
		for (int a = 0; a < 16; a += 4) wr(a[7:0], 32'hFFFFFFFF);
	endtask

	task automatic fire_ev(input int i, input logic t, input logic [1:0] c);
		@(posedge clk_in);
		sel <= i[4:0];
		paddr <= 32'hA0000000 + i;
		baddr <= 32'hB0000000 + i;
		fire <= 1'b1;
		@(posedge clk_in);
		fire <= 1'b0;
		#1;
		check("take", take, t);
		if (t) check("class", cls, c);
		@(posedge clk_in);
		#1;
		check("take drop", take, 1'b0);
	endtask

	task automatic pulse(input logic use_nmi);
		@(posedge clk_in);
		nmi <= use_nmi;
		dbg <= !use_nmi;
		@(posedge clk_in);
		nmi <= 1'b0;
		dbg <= 1'b0;
		#1;
	endtask

	task automatic reset_values();
		check("hresp", hresp, 1'b0);
		check("lockup", lock, 1'b0);
		for (int a = 0; a <= 36; a += 4) begin
			if (a != 16 && a != 20) rd_chk("reset value", a[7:0], 32'h00000000);
		end
	endtask

	task automatic classify_all();
		wr(`OFF_HANDLER_ENABLE, 32'h00000007);
		for (int i = 0; i < 17; i++) begin
			fire_ev(i, 1'b1, offs[i][3:2]);
			rd_chk("cause", offs[i], 32'h00000001 << bits[i]);
			if (i > 0 && i < 6) rd_chk("protect addr", `OFF_PROTECT_ADDR, 32'hA0000000 + i);
			if (i > 5 && i < 10) rd_chk("bus addr", `OFF_BUS_ADDR, 32'hB0000000 + i);
			wr(offs[i], 32'h00000001 << bits[i]);
			rd_chk("cleared", offs[i], 32'h00000000);
		end
		wr(8'h24, 32'hFFFFFFFF);
		rd_chk("unmapped", 8'h24, 32'h00000000);
		wr(`OFF_PROTECT_ADDR, 32'h00000000);
		rd_chk("read only", `OFF_PROTECT_ADDR, 32'hA0000005);
		rd_chk("status", `OFF_UNIT_STATUS, 32'h00000006);
	endtask

	task automatic ret_codes();
		logic [31:0] codes [7] = '{32'hFFFFFFF1, 32'hFFFFFFF9, 32'hFFFFFFFD, 32'hFFFFFFF0,
			32'hFFFFFFF2, 32'hFFFFFFFE, 32'h00000001};
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_in);
			rcode <= codes[i];
			rstb <= 1'b1;
			@(posedge clk_in);
			rstb <= 1'b0;
			rd_chk("return code", `OFF_USAGE_CAUSE, (i < 3) ? 32'h0 : 32'h00000008);
			clear_all();
		end
	endtask

	task automatic esc(input logic [2:0] cx, input logic [7:0] pr, input int i,
		input logic [1:0] c, input logic en);
		@(posedge clk_in);
		ctx <= cx;
		aprio <= pr;
		entry <= en;
		fire_ev(i, 1'b1, c);
		rd_chk("hard cause", `OFF_HARD_CAUSE, {30'h0, c == 2'h0 && i != 0, i == 0});
		clear_all();
	endtask

	task automatic escalation();
		wr(`OFF_HANDLER_ENABLE, 32'h00000000);
		esc(CTX_THREAD, 8'h00, 15, 2'h0, 1'b0);
		wr(`OFF_HANDLER_ENABLE, 32'h00000007);
		wr(`OFF_PRIO_CONFIG, 32'h00100000);
		rd_chk("priority", `OFF_PRIO_CONFIG, 32'h00100000);
		esc(CTX_THREAD, 8'h00, 15, 2'h3, 1'b0);
		esc(CTX_OTHER, 8'h11, 15, 2'h3, 1'b0);
		esc(CTX_OTHER, 8'h10, 15, 2'h0, 1'b0);
		esc(CTX_OTHER, 8'h0F, 15, 2'h0, 1'b0);
		esc(CTX_USAGE, 8'hFF, 15, 2'h0, 1'b0);
		esc(CTX_BUS, 8'hFF, 6, 2'h2, 1'b1);
		esc(CTX_BUS, 8'hFF, 6, 2'h0, 1'b0);
		esc(CTX_PROTECT, 8'h00, 0, 2'h0, 1'b0);
	endtask

	task automatic lock_case(input logic [2:0] cx);
		@(posedge clk_in);
		ctx <= cx;
		fire_ev(0, 1'b0, 2'h0);
		check("lockup", lock, 1'b1);
		fire_ev(15, 1'b0, 2'h0);
		pulse(1'b1);
		check("after nmi", lock, cx == CTX_NMI);
		pulse(1'b0);
		check("after halt", lock, 1'b0);
		clear_all();
	endtask

	// Frozen clock enable drops events; reset releases a lockup
	task automatic freeze_reset();
		@(posedge clk_in);
		ce <= 1'b0;
		fire_ev(16, 1'b0, 2'h0);
		@(posedge clk_in);
		ce <= 1'b1;
		rd_chk("frozen", `OFF_USAGE_CAUSE, 32'h00000000);
		fire_ev(0, 1'b0, 2'h0);
		check("lockup", lock, 1'b1);
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		check("reset release", lock, 1'b0);
		reset_values();
	endtask

	initial begin
		#100000;
		num_errors++;
		finish_test();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		reset_values();
		classify_all();
		ret_codes();
		escalation();
		lock_case(CTX_HARD);
		lock_case(CTX_NMI);
		freeze_reset();
		finish_test();
	end
endmodule
